/* verilog/spimsc_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spimsc_defines.svh"

module spimsc_core import spimsc_pkg::*; (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       cpu_irq_mask,
	input  wire logic       ctrl_wr,
	input  wire logic [7:0] ctrl_wdata,
	input  wire logic       csr_rd,
	input  wire logic       csr_wr,
	input  wire logic [7:0] csr_wdata,
	input  wire logic       data_rd,
	input  wire logic       data_wr,
	input  wire logic [7:0] data_wdata,
	output logic [7:0]      ctrl_rdata,
	output logic [7:0]      csr_rdata,
	output logic [7:0]      data_rdata,
	output logic            irq,
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe,
	input  wire logic       mosi_in,
	output logic            mosi_out,
	output logic            mosi_oe,
	input  wire logic       miso_in,
	output logic            miso_out,
	output logic            miso_oe,
	input  wire logic       ss_n_in
);

	spimsc_core_t q, d;

	logic       port_en;
	logic       master;
	logic       cpol;
	logic       cpha;
	logic       irq_en;
	logic [2:0] rate;
	logic       ss_int;
	logic       slave_busy;
	logic       busy;
	logic       slave_edge;
	logic       m_done;
	logic       byte_done;
	logic [7:0] rx_new;
	logic       csr_acc;
	logic [2:0] out_idx;
	logic [7:0] rx_byte;
	logic       done_tgl;
	logic       start_tgl;

	// half period of master sck in clk cycles, minus one for the counter
	function automatic logic [8:0] half_reload(input logic [2:0] r);
		logic [8:0] base;
		base = 9'(`SPIMSC_HALF_CYC);
		half_reload = (base << r) - 9'h001;
	endfunction

	assign port_en = q.ctrl[`SPIMSC_CR_PORT_EN];
	assign master  = q.ctrl[`SPIMSC_CR_MASTER];
	assign cpol    = q.ctrl[`SPIMSC_CR_CPOL];
	assign cpha    = q.ctrl[`SPIMSC_CR_CPHA];
	assign irq_en  = q.ctrl[`SPIMSC_CR_IRQ_EN];
	assign rate    = {q.ctrl[`SPIMSC_CR_RATE2],
		q.ctrl[`SPIMSC_CR_RATE1], q.ctrl[`SPIMSC_CR_RATE0]};

	// the pin is ignored entirely in software mode
	assign ss_int = q.swsel ? q.swlvl : q.ss_s2;

	// phase one may hold select low across bytes, so use link activity
	assign slave_busy = cpha ?
		((q.start_sy[1] ^ q.done_sy[1]) & ~q.link_rst) :
		(~ss_int & port_en);
	assign busy = master ? (q.ph != ph_idle) : slave_busy;
	assign slave_edge = q.done_sy[1] ^ q.done_sy[2];
	assign csr_acc = csr_rd | csr_wr;

	spimsc_link u_link (
		.sck_in    (sck_in),
		.reset     (reset),
		.link_rst  (q.link_rst),
		.cpol      (cpol),
		.cpha      (cpha),
		.mosi_in   (mosi_in),
		.out_idx   (out_idx),
		.rx_byte   (rx_byte),
		.done_tgl  (done_tgl),
		.start_tgl (start_tgl)
	);

	always_comb begin
		d = q;
		m_done = 1'b0;

		d.ss_s1 = ss_n_in;
		d.ss_s2 = q.ss_s1;
		d.miso_s1 = miso_in;
		d.miso_s2 = q.miso_s1;
		d.done_sy = {q.done_sy[1:0], done_tgl};
		d.start_sy = {q.start_sy[1:0], start_tgl};
		// link logic runs only while selected as an enabled slave
		d.link_rst = ~(port_en & ~master & ~ss_int);

		// done flag clearing sequence
		if (q.done_arm & (data_rd | (~master & data_wr))) begin
			d.done = 1'b0;
			d.done_arm = 1'b0;
			d.done_rd = 1'b0;
		end
		if (csr_acc & q.done) begin
			d.done_arm = 1'b1;
		end
		if (csr_rd & q.done) begin
			d.done_rd = 1'b1;
		end

		if (csr_rd) begin
			d.ovrun = 1'b0;
		end

		if (q.coll_arm & data_rd) begin
			d.coll = 1'b0;
			d.coll_arm = 1'b0;
		end
		if (csr_rd & q.coll) begin
			d.coll_arm = 1'b1;
		end

		if (ctrl_wr & q.fault_arm) begin
			d.fault = 1'b0;
			d.fault_arm = 1'b0;
		end
		if (csr_rd & q.fault) begin
			d.fault_arm = 1'b1;
		end

		if (ctrl_wr) begin
			d.ctrl = ctrl_wdata;
			if (q.fault & ~q.fault_arm) begin
				// outside the clearing write these two may only fall
				d.ctrl[`SPIMSC_CR_PORT_EN] = ctrl_wdata[`SPIMSC_CR_PORT_EN] &
					q.ctrl[`SPIMSC_CR_PORT_EN];
				d.ctrl[`SPIMSC_CR_MASTER] = ctrl_wdata[`SPIMSC_CR_MASTER] &
					q.ctrl[`SPIMSC_CR_MASTER];
			end
		end

		if (csr_wr) begin
			d.swsel = csr_wdata[`SPIMSC_SR_SWSEL];
			d.swlvl = csr_wdata[`SPIMSC_SR_SWLVL];
		end

		// only a master can fault; the write that sets master is checked too
		if (d.ctrl[`SPIMSC_CR_MASTER] & ~ss_int) begin
			d.fault = 1'b1;
			d.fault_arm = 1'b0;
			d.ctrl[`SPIMSC_CR_PORT_EN] = 1'b0;
			d.ctrl[`SPIMSC_CR_MASTER] = 1'b0;
		end

		// master sck engine
		unique case (q.ph)
			ph_idle: begin
				d.sck = cpol;
			end
			ph_lead: begin
				if (q.div == 9'h000) begin
					d.sck = ~cpol;
					d.div = half_reload(rate);
					d.ph = ph_trail;
					if (!cpha) begin
						d.shreg = {q.shreg[6:0], q.miso_s2};
					end else begin
						d.mosi = q.shreg[7];
					end
				end else begin
					d.div = q.div - 9'h001;
				end
			end
			ph_trail: begin
				if (q.div == 9'h000) begin
					d.sck = cpol;
					d.div = half_reload(rate);
					if (cpha) begin
						d.shreg = {q.shreg[6:0], q.miso_s2};
					end
					if (q.bits == `SPIMSC_LAST_BIT) begin
						m_done = 1'b1;
						d.ph = ph_idle;
					end else begin
						d.bits = q.bits + 3'h1;
						d.ph = ph_lead;
						if (!cpha) begin
							d.mosi = q.shreg[7];
						end
					end
				end else begin
					d.div = q.div - 9'h001;
				end
			end
			default: begin
				d.ph = ph_idle;
			end
		endcase

		// leaving master mode or disabling aborts the byte
		if (!d.ctrl[`SPIMSC_CR_MASTER] || !d.ctrl[`SPIMSC_CR_PORT_EN]) begin
			d.ph = ph_idle;
			d.sck = d.ctrl[`SPIMSC_CR_CPOL];
			m_done = 1'b0;
		end

		// data_reg write: blocked while done is pending an unread status
		if (data_wr & ~(q.done & ~q.done_rd)) begin
			if (busy) begin
				d.coll = 1'b1;
			end else if (master & port_en) begin
				d.shreg = data_wdata;
				d.mosi = data_wdata[7];
				d.div = half_reload(rate);
				d.bits = 3'h0;
				d.ph = ph_lead;
			end else begin
				d.tx_word = data_wdata;
			end
		end

		byte_done = m_done | (~master & slave_edge);
		rx_new = m_done ? d.shreg : rx_byte;

		// setting wins over any clear in the same cycle
		if (byte_done) begin
			if (q.done) begin
				d.ovrun = 1'b1;
				d.done = 1'b1;
			end else begin
				d.done = 1'b1;
				d.done_arm = 1'b0;
				d.done_rd = 1'b0;
				d.rx_buf = rx_new;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// collision is deliberately absent from the request
	assign irq = irq_en & ~cpu_irq_mask &
		(q.done | q.ovrun | q.fault);

	assign ctrl_rdata = q.ctrl;
	assign csr_rdata  = {q.done, q.coll, q.ovrun, q.fault, 2'b00,
		q.swsel, q.swlvl};
	assign data_rdata = q.rx_buf;

	// pins are released whenever the port is off
	assign sck_out  = q.sck;
	assign sck_oe   = port_en & master;
	assign mosi_out = q.mosi;
	assign mosi_oe  = port_en & master;
	// tx_word is frozen during a byte, so this mux is stable per bit
	assign miso_out = q.tx_word[3'h7 - out_idx];
	assign miso_oe  = port_en & ~master & ~ss_int;

endmodule // spimsc_core

`default_nettype wire

/* verilog/spimsc_defines.svh */
`ifndef SPIMSC_DEFINES_SVH
`define SPIMSC_DEFINES_SVH

// control_reg fields
`define SPIMSC_CR_IRQ_EN  7
`define SPIMSC_CR_PORT_EN 6
`define SPIMSC_CR_RATE2   5
`define SPIMSC_CR_MASTER  4
`define SPIMSC_CR_CPOL    3
`define SPIMSC_CR_CPHA    2
`define SPIMSC_CR_RATE1   1
`define SPIMSC_CR_RATE0   0

// control_status_reg fields
`define SPIMSC_SR_DONE    7
`define SPIMSC_SR_COLL    6
`define SPIMSC_SR_OVRUN   5
`define SPIMSC_SR_FAULT   4
`define SPIMSC_SR_SWSEL   1
`define SPIMSC_SR_SWLVL   0

// reset values
`define SPIMSC_CR_RESET   8'h00
`define SPIMSC_SR_RESET   8'h00
`define SPIMSC_DR_RESET   8'h00

// timing: shortest sck half period, rounded up to clk cycles
`define SPIMSC_CLK_MHZ     100
`define SPIMSC_SCK_HALF_NS 20
`define SPIMSC_HALF_CYC \
	((`SPIMSC_SCK_HALF_NS * `SPIMSC_CLK_MHZ + 999) / 1000)
`define SPIMSC_LAST_BIT   3'h7

`endif

/* verilog/spimsc_pkg.sv */
`include "spimsc_defines.svh"

package spimsc_pkg;

	typedef enum logic [1:0] {
		ph_idle  = 2'b00,
		ph_lead  = 2'b01,
		ph_trail = 2'b11
	} spimsc_phase_t;

	typedef struct packed {
		logic [7:0]    ctrl;
		logic          swsel;
		logic          swlvl;
		logic          done;
		logic          coll;
		logic          ovrun;
		logic          fault;
		logic          done_arm;
		logic          done_rd;
		logic          coll_arm;
		logic          fault_arm;
		logic [7:0]    rx_buf;
		logic [7:0]    tx_word;
		logic [7:0]    shreg;
		logic          mosi;
		logic          sck;
		spimsc_phase_t ph;
		logic [8:0]    div;
		logic [2:0]    bits;
		logic          ss_s1;
		logic          ss_s2;
		logic          miso_s1;
		logic          miso_s2;
		logic [2:0]    done_sy;
		logic [2:0]    start_sy;
		logic          link_rst;
	} spimsc_core_t;

	typedef struct packed {
		logic [7:0] sh;
		logic [2:0] cnt;
	} spimsc_link_t;

endpackage

/* verilog/spimsc_link.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spimsc_defines.svh"

module spimsc_link import spimsc_pkg::*; (
	input  wire logic       sck_in,
	input  wire logic       reset,
	input  wire logic       link_rst,
	input  wire logic       cpol,
	input  wire logic       cpha,
	input  wire logic       mosi_in,
	output logic [2:0]      out_idx,
	output logic [7:0]      rx_byte,
	output logic            done_tgl,
	output logic            start_tgl
);

	spimsc_link_t q, d;
	logic         lclk;

	// capture edge is always rising on lclk; config only moves while off
	assign lclk = sck_in ^ cpol ^ cpha;

	always_comb begin
		d = q;
		d.sh = {q.sh[6:0], mosi_in};
		d.cnt = q.cnt + 3'h1;
	end

	always_ff @(posedge lclk or posedge link_rst) begin
		if (link_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// toggles survive link_rst so the clk side never sees a false edge
	always_ff @(posedge lclk or posedge reset) begin
		if (reset) begin
			rx_byte   <= `SPIMSC_DR_RESET;
			done_tgl  <= 1'b0;
			start_tgl <= 1'b0;
		end else if (!link_rst) begin
			if (q.cnt == 3'h0) begin
				start_tgl <= ~start_tgl;
			end
			if (q.cnt == `SPIMSC_LAST_BIT) begin
				rx_byte  <= d.sh;
				done_tgl <= ~done_tgl;
			end
		end
	end

	// miso bit index moves on the launch edge, msb first
	always_ff @(negedge lclk or posedge link_rst) begin
		if (link_rst) begin
			out_idx <= 3'h0;
		end else begin
			out_idx <= q.cnt;
		end
	end

endmodule // spimsc_link

`default_nettype wire

/* test/spimsc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module spimsc_monitor (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       cpu_irq_mask,
	input wire logic       ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic       csr_rd,
	input wire logic [7:0] ctrl_rdata,
	input wire logic [7:0] csr_rdata,
	input wire logic       irq,
	input wire logic       sck_out,
	input wire logic       sck_oe,
	input wire logic       miso_oe
);
	logic arm_q;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	always_ff @(posedge clk or posedge reset)
		if (reset)
			arm_q <= 1'b0;
		else if (ctrl_wr)
			arm_q <= 1'b0;
		else if (csr_rd && csr_rdata[4])
			arm_q <= 1'b1;
	sequence s_fault_set;
		!csr_rdata[4] ##1 csr_rdata[4];
	endsequence
	sequence s_ovr_read;
		csr_rd && csr_rdata[5];
	endsequence
	AST_IRQ_MASK: assert property (cpu_irq_mask |-> !irq)
		else $error("irq while masked");
	AST_IRQ_SRC: assert property (irq |-> ctrl_rdata[7] &&
		(csr_rdata[7] || csr_rdata[5] || csr_rdata[4]))
		else $error("irq without source");
	AST_OVR_CLR: assert property (s_ovr_read |=> !csr_rdata[5])
		else $error("overrun kept");
	AST_FAULT_DROP: assert property (s_fault_set |-> ##[0:1]
		(!ctrl_rdata[6] && !ctrl_rdata[4]))
		else $error("enables kept on fault");
	AST_FAULT_MST: assert property (s_fault_set |->
		$past(ctrl_rdata[4]) || $past(ctrl_wr && ctrl_wdata[4]))
		else $error("fault as slave");
	AST_FAULT_LOCK: assert property (csr_rdata[4] && !arm_q &&
		ctrl_wr && !ctrl_rdata[6] |=> !ctrl_rdata[6])
		else $error("enable set under fault");
	AST_MISO_OE: assert property (miso_oe |->
		ctrl_rdata[6] && !ctrl_rdata[4])
		else $error("miso driven wrongly");
	AST_SCK_IDLE: assert property ($rose(csr_rdata[7]) &&
		sck_oe |-> sck_out == ctrl_rdata[3])
		else $error("sck not idle");
	AST_SCK_OE: assert property ($rose(ctrl_rdata[6] &&
		ctrl_rdata[4]) |-> ##[0:1] sck_oe)
		else $error("sck not driven");
endmodule // spimsc_monitor
`default_nettype wire

/* test/spimsc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module spimsc_peer (
	input  wire logic  sck,
	input  wire logic  mosi,
	input  wire logic  miso,
	input  wire logic  cpol,
	input  wire logic  cpha,
	output logic       sck_drv,
	output logic       mosi_drv,
	output logic       miso_drv,
	output logic       ss_n,
	output logic [7:0] rx_mosi,
	output logic [7:0] rx_miso
);
	logic [7:0] sh;
	logic       cap;
	initial begin
		sck_drv = 1'b0;
		mosi_drv = 1'b0;
		ss_n = 1'b1;
		sh = 8'h00;
		cap = 1'b0;
	end
	assign miso_drv = sh[7];
	always @(sck)
		if (sck ^ cpol ^ cpha) begin
			rx_mosi = {rx_mosi[6:0], mosi};
			rx_miso = {rx_miso[6:0], miso};
			cap = 1'b1;
		end else if (cap)
			sh = {sh[6:0], ~sh[7]}; // spent bits toggle, never stale
	task automatic load(input logic [7:0] b);
		sh = b;
		cap = 1'b0;
	endtask
	task automatic frame(input logic [7:0] b);
		sck_drv = cpol;
		ss_n = 1'b0;
		#45; // select must clear the 2-flop sync first
		for (int i = 7; i >= 0; i--) begin
			if (!cpha)
				mosi_drv = b[i];
			#3 sck_drv = ~sck_drv;
			if (cpha)
				mosi_drv = b[i];
			#3 sck_drv = ~sck_drv;
		end
		#5 ss_n = 1'b1;
		mosi_drv = ~mosi_drv;
	endtask
endmodule // spimsc_peer
`default_nettype wire

/* test/test_spimsc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module test_spimsc_core;
	logic       clk;
	logic       reset;
	logic       cpu_irq_mask;
	logic [4:0] stb;
	logic [7:0] wd, ctrl_rdata, csr_rdata, data_rdata, p_rxo, p_rxi, c;
	logic       irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
	logic       p_sck, p_mosi, p_miso, p_ss_n;
	int         err_count, n_checks, cyc;
	wire        sck_w = sck_oe ? sck_out : p_sck;
	wire        mosi_w = mosi_oe ? mosi_out : p_mosi;
	wire        miso_w = miso_oe ? miso_out : p_miso;
	spimsc_core dut (
		.clk, .reset, .cpu_irq_mask,
		.ctrl_wr(stb[0]), .ctrl_wdata(wd), .csr_wr(stb[1]), .csr_wdata(wd),
		.data_wr(stb[2]), .data_wdata(wd), .csr_rd(stb[3]), .data_rd(stb[4]),
		.ctrl_rdata, .csr_rdata, .data_rdata, .irq,
		.sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out,
		.mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .ss_n_in(p_ss_n)
	);
	spimsc_peer peer (
		.sck(sck_w), .mosi(mosi_w), .miso(miso_w), .cpol(ctrl_rdata[3]),
		.cpha(ctrl_rdata[2]), .sck_drv(p_sck), .mosi_drv(p_mosi),
		.miso_drv(p_miso), .ss_n(p_ss_n), .rx_mosi(p_rxo), .rx_miso(p_rxi)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up;
		end
	end
	// k: 0 ctrl wr, 1 csr wr, 2 data wr, 3 csr rd, 4 data rd
	task automatic acc(input int k, input logic [7:0] v);
		@(negedge clk);
		wd = v;
		stb[k] = 1'b1;
		@(negedge clk);
		stb = '0;
	endtask
	task automatic cmp(input string n, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	initial begin
		reset = 1'b1;
		cpu_irq_mask = 1'b0;
		stb = '0;
		wd = '0;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		for (int m = 0; m < 4; m++) begin
			c = {4'h0, 2'(m), 2'b01};
			cpu_irq_mask = (m == 3);
			acc(0, c);
			acc(1, 8'h03);
			acc(0, c | 8'hd0);
			peer.load(8'h69 ^ c);
			cmp("sck idle", 8'(c[3]), 8'(sck_out));
			cmp("mosi oe", 8'h01, 8'(mosi_oe));
			acc(2, 8'h9c + c);
			acc(2, 8'h00);
			for (int i = 0; i < 200 && csr_rdata[7] !== 1'b1; i++) @(negedge clk);
			cmp("mosi", 8'h9c + c, p_rxo);
			cmp("irq", 8'(m != 3), 8'(irq));
			acc(2, 8'h11);
			cmp("csr", 8'hc3, csr_rdata);
			acc(3, 8'h00);
			acc(4, 8'h00);
			cmp("miso", 8'h69 ^ c, data_rdata);
			cmp("csr", 8'h03, csr_rdata);
			acc(0, c);
		end
		$display("test master modes ended");
		cpu_irq_mask = 1'b0;
		acc(1, 8'h00);
		acc(0, 8'hd0);
		peer.ss_n = 1'b0;
		repeat (4) @(negedge clk);
		cmp("ctrl", 8'h80, ctrl_rdata);
		cmp("csr", 8'h10, csr_rdata);
		cmp("irq", 8'h01, 8'(irq));
		peer.ss_n = 1'b1;
		acc(0, 8'hd0);
		cmp("ctrl", 8'h80, ctrl_rdata);
		acc(3, 8'h00);
		acc(0, 8'h50);
		cmp("ctrl", 8'h50, ctrl_rdata);
		cmp("csr", 8'h00, csr_rdata);
		acc(0, 8'h00);
		$display("test mode fault ended");
		acc(0, 8'hc0);
		acc(2, 8'h96);
		peer.frame(8'h5a);
		repeat (6) @(negedge clk);
		cmp("tx", 8'h96, p_rxi);
		cmp("rx", 8'h5a, data_rdata);
		peer.frame(8'hc3);
		repeat (6) @(negedge clk);
		cmp("csr", 8'ha0, csr_rdata);
		cmp("rx", 8'h5a, data_rdata);
		acc(3, 8'h00);
		cmp("csr", 8'h80, csr_rdata);
		acc(2, 8'h77);
		cmp("csr", 8'h00, csr_rdata);
		peer.ss_n = 1'b0;
		repeat (3) @(negedge clk);
		acc(2, 8'h11);
		cmp("csr", 8'h40, csr_rdata);
		cmp("irq", 8'h00, 8'(irq));
		peer.ss_n = 1'b1;
		acc(1, 8'h02);
		repeat (3) @(negedge clk);
		cmp("miso oe", 8'h01, 8'(miso_oe));
		$display("test slave ended");
		wrap_up;
	end
endmodule // test_spimsc_core
bind spimsc_core spimsc_monitor mon (
	.clk, .reset, .cpu_irq_mask, .ctrl_wr, .ctrl_wdata, .csr_rd,
	.ctrl_rdata, .csr_rdata, .irq, .sck_out, .sck_oe, .miso_oe
);
`default_nettype wire
